//--- sixteen_bit_timer_counter_tb.sv
/* self-checking bench for the timer: register tasks, read queue.
   assumes the capture pin source model beside the timer. */
`timescale 1ns/100ps
module sixteen_bit_timer_counter_tb;
    // design drive and view
    reg          clock = 1'b0;
    reg          arst_n = 1'b0;
    reg          reg_sel = 1'b0;
    reg          reg_write = 1'b0;
    reg  [7:0]   reg_addr = 8'h00;
    reg  [31:0]  reg_wdata = 32'h0;
    wire [31:0]  reg_rdata;
    wire         cap_pin;
    wire [1:0]   match_pins;
    wire         irq;
    // pin source control
    reg          start = 1'b0;
    reg  [3:0]   pulses = 4'h1;
    reg  [2:0]   hold = 3'h2;
    wire         busy;
    // scoreboard and scratch
    logic [39:0] notes[$];
    reg          rd_pend = 1'b0;
    integer      num_errors = 0;
    integer      check_count = 0;
    integer      seed = 32'hA64C;
    integer      i, n, pr;
    reg  [15:0]  v;
    localparam [119:0] ALL = {8'h00,8'h04,8'h08,8'h0C,8'h10,8'h14,8'h18,8'h1C,8'h20,8'h24,8'h28,8'h2C,8'h3C,8'h70,8'h74};
    localparam [55:0]  RW = {8'h08, 8'h10, 8'h0C, 8'h18, 8'h1C, 8'h20, 8'h24};

    always #2 clock = ~clock;

    tmr16_timer tmr16_timer_inst (.CLOCK(clock), .ARST_N(arst_n), .REG_SEL(reg_sel), .REG_WRITE(reg_write),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .CAPTURE_INPUT_PIN(cap_pin),
        .MATCH_OUTPUT_PINS(match_pins), .IRQ(irq));
    tmr16_pin_source tmr16_pin_source_inst (.CLOCK(clock), .START(start), .PULSES(pulses), .HOLD(hold),
        .PIN(cap_pin), .BUSY(busy));

    // counts and reports one comparison
    task check(input string what, input [31:0] exp, input [31:0] seen);
        check_count = check_count + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one register write, taken at the next edge
    task wr(input [7:0] a, input [31:0] d);
        reg_sel   <= 1'b1;
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
    endtask
    // one register read; the expected answer is noted for the monitor
    task rd(input [7:0] a, input [31:0] e);
        reg_sel   <= 1'b1;
        reg_write <= 1'b0;
        reg_addr  <= a;
        notes.push_back({a, e});
        @(posedge clock);
    endtask
    // bus quiet for c edges
    task idle(input integer c);
        reg_sel <= 1'b0;
        repeat (c) @(posedge clock);
    endtask
    // burst of p pulses of random width on the capture pin
    task pins(input [3:0] p);
        reg_sel <= 1'b0;
        pulses  <= p;
        hold    <= 3'd2 + 3'({$random(seed)} % 4);
        start   <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        @(posedge clock);
        while (busy) @(posedge clock);
    endtask
    task done(input string s);
        $display("test %s done", s);
    endtask
    // verdict and end of run
    task summarize;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // compares each read answer with the oldest note
    always @(posedge clock) begin
        if (rd_pend) begin
            check($sformatf("reg %h", notes[0][39:32]), notes[0][31:0], reg_rdata);
            void'(notes.pop_front());
        end
        rd_pend <= reg_sel && !reg_write;
    end

    // cuts a hang short
    initial begin
        #40000;
        num_errors = num_errors + 1;
        summarize;
    end

    initial begin
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        for (i = 0; i < 16; i = i + 1)
            rd(i < 15 ? ALL[8*i +: 8] : 8'h40, 32'h0);
        done("reset");
        for (i = 0; i < 7; i = i + 1) begin
            v = 16'($random(seed));
            wr(RW[8*i +: 8], {16'h0, v});
            rd(RW[8*i +: 8], {16'h0, v});
        end
        done("readback");
        pr = {$random(seed)} % 6;
        n = 10 + {$random(seed)} % 30;
        wr(8'h0C, pr);
        wr(8'h08, 0);
        wr(8'h10, 0);
        wr(8'h04, 32'h1);
        idle(n);
        wr(8'h04, 32'h0);
        idle(3);
        rd(8'h08, (n + 1) / (pr + 1));
        rd(8'h10, (n + 1) % (pr + 1));
        done("prescale");
        wr(8'h08, 32'hFFFE);
        wr(8'h0C, 0);
        wr(8'h10, 0);
        wr(8'h04, 32'h1);
        idle(2);
        wr(8'h04, 32'h0);
        rd(8'h08, 32'h1);
        rd(8'h00, 32'h0);
        wr(8'h04, 32'h3);
        idle(1);
        rd(8'h08, 32'h0);
        wr(8'h08, 32'h55);
        idle(1);
        rd(8'h08, 32'h0);
        rd(8'h10, 32'h0);
        done("wrap and clear");
        for (i = 0; i < 4; i = i + 1) begin
            v = 16'd5 + 16'({$random(seed)} % 20);
            wr(8'h18 + 4 * i, {16'h0, v});
            wr(8'h04, 32'h0);
            wr(8'h08, 32'h0);
            wr(8'h14, 32'h5 << (3 * i));
            wr(8'h04, 32'h1);
            idle(40);
            check("irq", 32'h1, {31'h0, irq});
            rd(8'h08, {16'h0, v});
            rd(8'h04, 32'h0);
            rd(8'h00, 32'h1 << i);
            wr(8'h00, 32'h0);
            rd(8'h00, 32'h1 << i);
            wr(8'h00, 32'h1 << i);
            idle(2);
            check("irq", 32'h0, {31'h0, irq});
            rd(8'h00, 32'h0);
        end
        wr(8'h14, 32'h0);
        done("match");
        wr(8'h08, {16'h0, v});
        wr(8'h28, 32'h5);
        pins(1);
        rd(8'h2C, {16'h0, v});
        rd(8'h00, 32'h10);
        wr(8'h00, 32'h10);
        wr(8'h08, 32'h0777);
        wr(8'h28, 32'h2);
        pins(1);
        wr(8'h2C, 32'h0);
        rd(8'h2C, 32'h0777);
        rd(8'h00, 32'h0);
        done("capture");
        n = 1 + {$random(seed)} % 7;
        wr(8'h28, 32'h0);
        wr(8'h70, 32'h1);
        wr(8'h08, 32'h0);
        wr(8'h04, 32'h1);
        pins(n[3:0]);
        wr(8'h04, 32'h0);
        wr(8'h70, 32'h0);
        rd(8'h08, n);
        wr(8'h3C, 32'h3);
        idle(2);
        check("pins", 32'h3, {30'h0, match_pins});
        wr(8'h18, 32'h0);
        wr(8'h1C, 32'hFFFF);
        wr(8'h74, 32'h3);
        idle(2);
        check("pins", 32'h1, {30'h0, match_pins});
        done("count mode and pins");
        idle(3);
        summarize;
    end
endmodule // sixteen_bit_timer_counter_tb

//--- tmr16_consts.vh
/*
 * register offsets, field positions, widths and reset values of the
 * sixteen-bit counter/timer; definitions only, included by bare name
 * by the timer module; the edge detector does not include it.
 */
`ifndef TMR16_CONSTS_VH
`define TMR16_CONSTS_VH

// register byte offsets
`define OFS_IRQ_FLAGS      8'h00
`define OFS_TIMER_CONTROL  8'h04
`define OFS_TIMER_COUNT    8'h08
`define OFS_PRESCALE_LIMIT 8'h0C
`define OFS_PRESCALE_COUNT 8'h10
`define OFS_MATCH_CONTROL  8'h14
`define OFS_MATCH_VALUE_0  8'h18
`define OFS_MATCH_VALUE_1  8'h1C
`define OFS_MATCH_VALUE_2  8'h20
`define OFS_MATCH_VALUE_3  8'h24
`define OFS_CAPTURE_CTRL   8'h28
`define OFS_CAPTURE_VALUE  8'h2C
`define OFS_EXT_MATCH      8'h3C
`define OFS_COUNT_MODE     8'h70
`define OFS_PULSE_WIDTH    8'h74

// field positions
`define BIT_COUNT_ENABLE   0
`define BIT_COUNT_CLEAR    1
`define BIT_CAPTURE_FLAG   4
`define CCR_RISE           0
`define CCR_FALL           1
`define CCR_IRQ            2
`define COUNT_MODE_REG_MODE_LSB      0
`define COUNT_MODE_REG_MODE_MSB      1
`define EMR_MATCH_ACTIONS  4

// widths and reset values
`define COUNT_WIDTH        16
`define FLAG_WIDTH         5
`define MCR_WIDTH          12
`define EMR_WIDTH          8
`define CCR_WIDTH          3
`define COUNT_MODE_REG_WIDTH         4
`define PWM_WIDTH          2
`define RESET_ZERO         32'h00000000

`endif

//--- tmr16_edge_detect.v
/*
 * edge detector for a synchronous pin input: registers the previous
 * level and reports rising and falling edges as one-cycle pulses.
 * assumes the pin is already synchronous to the clock.
 */
`timescale 1ns/100ps
module tmr16_edge_detect (
    // clock and reset
    input  wire CLOCK,
    input  wire ARST_N,
    // pin level
    input  wire PIN_LEVEL,
    // edge pulses
    output wire ROSE,
    output wire FELL
);
    reg last_reg; // pin level one cycle ago

    // remember the previous level
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            last_reg <= 1'b0;
        end else begin
            last_reg <= PIN_LEVEL;
        end
    end

    assign ROSE = PIN_LEVEL & ~last_reg;
    assign FELL = ~PIN_LEVEL & last_reg;
endmodule // tmr16_edge_detect

//--- tmr16_pin_source.sv
/* far side of the capture pin: bursts of pulses on request.
   assumes the timer clock; pulse width varies with HOLD. */
`timescale 1ns/100ps
module tmr16_pin_source (
    // clock
    input  wire       CLOCK,
    // burst request
    input  wire       START,
    input  wire [3:0] PULSES,
    input  wire [2:0] HOLD,
    // pin and status
    output reg        PIN,
    output reg        BUSY
);
    // pin idles low between bursts
    initial begin
        PIN  = 1'b0;
        BUSY = 1'b0;
    end
    // wide high and low phases keep each edge separate
    always begin
        @(posedge CLOCK);
        if (START) begin
            BUSY <= 1'b1;
            repeat (PULSES) begin
                repeat (HOLD) @(posedge CLOCK);
                PIN <= 1'b1;
                repeat (HOLD) @(posedge CLOCK);
                PIN <= 1'b0;
            end
            repeat (HOLD) @(posedge CLOCK);
            BUSY <= 1'b0;
        end
    end
endmodule // tmr16_pin_source

//--- tmr16_timer.v
/*
 * sixteen-bit counter/timer: prescaler, timer count, four match
 * channels, one capture channel, two external match outputs and a
 * simple register port. assumes a single-cycle register port that is
 * synchronous to CLOCK; reads return data one cycle after the strobe.
 */
`timescale 1ns/100ps
`include "tmr16_consts.vh"

// Overview of operation
// - flags: match 0..3 bits 0..3, capture bit 4
// - flag set when its source fires
// - writing one clears a flag, zero ignored
// - enable bit lets both counters count
// - clear bit holds both counters at zero
// - timer advances every limit plus one count ticks
// - prescaler wraps to zero after reaching limit
// - timer wraps at maximum without interrupt
// - software reads and writes both counters
// - matches clear, stop or interrupt per control
// - capture register loads timer on pin event, in timer mode only
// - capture control picks edges and interrupt
// - external match register drives two match pins
// - count mode selects timer or counter edges
// - pulse width control puts match pins in pwm
// - all implemented bits reset to zero
// - per channel: interrupt, clear, stop bits
module tmr16_timer (
    // clock and reset
    input  wire        CLOCK,
    input  wire        ARST_N,
    // register port
    input  wire        REG_SEL,
    input  wire        REG_WRITE,
    input  wire [7:0]  REG_ADDR,
    input  wire [31:0] REG_WDATA,
    output reg  [31:0] REG_RDATA,
    // pins
    input  wire        CAPTURE_INPUT_PIN,
    output reg  [1:0]  MATCH_OUTPUT_PINS,
    output reg         IRQ
);
    // registers
    reg [`FLAG_WIDTH-1:0]  irq_flag_reg;            // sticky flags
    reg [1:0]              timer_control_reg;       // enable and clear
    reg [`COUNT_WIDTH-1:0] timer_count_value;       // timer count
    reg [`COUNT_WIDTH-1:0] prescale_limit_value;    // prescale limit
    reg [`COUNT_WIDTH-1:0] prescale_count_value;    // prescale count
    reg [`MCR_WIDTH-1:0]   match_control_reg;       // per-channel actions
    reg [`COUNT_WIDTH-1:0] match_value_reg [0:3];   // match values
    reg [`CCR_WIDTH-1:0]   capture_control_reg;     // capture edges and irq
    reg [`COUNT_WIDTH-1:0] capture_value_zero;      // captured timer value
    reg [`EMR_WIDTH-1:0]   external_match_reg;      // match pins and actions
    reg [`COUNT_MODE_REG_WIDTH-1:0]  count_mode_reg;          // timer or counter mode
    reg [`PWM_WIDTH-1:0]   pulse_width_control_reg; // pwm enables
    reg [1:0]              match_hit_reg;           // match seen on last cycle

    // edges of the capture pin
    wire cap_rise;
    wire cap_fall;
    wire wr_en = REG_SEL & REG_WRITE;

    tmr16_edge_detect cap_edges (
        .CLOCK     (CLOCK),
        .ARST_N    (ARST_N),
        .PIN_LEVEL (CAPTURE_INPUT_PIN),
        .ROSE      (cap_rise),
        .FELL      (cap_fall)
    );

    // capture event per selected edges
    wire cap_event = (capture_control_reg[`CCR_RISE] & cap_rise) |
                     (capture_control_reg[`CCR_FALL] & cap_fall);

    // count tick source: pclk in timer mode, pin edges in counter mode
    reg count_tick;
    always @* begin
        case (count_mode_reg[`COUNT_MODE_REG_MODE_MSB:`COUNT_MODE_REG_MODE_LSB])
            2'h0:    count_tick = 1'b1;
            2'h1:    count_tick = cap_rise;
            2'h2:    count_tick = cap_fall;
            2'h3:    count_tick = cap_rise | cap_fall;
            default: count_tick = 1'b1;
        endcase
    end

    // counting allowed only while enabled and not held clear
    wire run = timer_control_reg[`BIT_COUNT_ENABLE] &
               ~timer_control_reg[`BIT_COUNT_CLEAR];
    // prescaler terminal count reached
    wire pre_term = (prescale_count_value == prescale_limit_value);
    wire tc_step  = run & count_tick & pre_term;

    // per-channel match compare and actions
    wire [3:0] match_eq;
    wire [3:0] match_irq;
    wire [3:0] match_clr;
    wire [3:0] match_stop;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_match
            assign match_eq[gi]   = run & (timer_count_value == match_value_reg[gi]);
            assign match_irq[gi]  = match_eq[gi] & match_control_reg[3*gi];
            assign match_clr[gi]  = match_eq[gi] & match_control_reg[3*gi+1];
            assign match_stop[gi] = match_eq[gi] & match_control_reg[3*gi+2];
        end
    endgenerate

    // counters, control and match-driven clear/stop
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            timer_control_reg    <= 2'h0;
            timer_count_value    <= 16'h0000;
            prescale_count_value <= 16'h0000;
        end else begin
            // control register write; stop on match clears enable
            if (wr_en && REG_ADDR == `OFS_TIMER_CONTROL) begin
                timer_control_reg <= REG_WDATA[1:0];
            end else if (|match_stop) begin
                timer_control_reg[`BIT_COUNT_ENABLE] <= 1'b0;
            end
            if (timer_control_reg[`BIT_COUNT_CLEAR]) begin
                // held at zero while clear bit set
                timer_count_value    <= 16'h0000;
                prescale_count_value <= 16'h0000;
            end else begin
                // software overwrite of the counters
                if (wr_en && REG_ADDR == `OFS_TIMER_COUNT) begin
                    timer_count_value <= REG_WDATA[15:0];
                end else if (|match_stop) begin
                    timer_count_value <= timer_count_value; // stop holds
                end else if (tc_step) begin
                    if (|match_clr) begin
                        timer_count_value <= 16'h0000;      // clear on match
                    end else begin
                        timer_count_value <= timer_count_value + 16'h0001; // wraps
                    end
                end
                if (wr_en && REG_ADDR == `OFS_PRESCALE_COUNT) begin
                    prescale_count_value <= REG_WDATA[15:0];
                end else if (|match_stop) begin
                    prescale_count_value <= prescale_count_value;
                end else if (run && count_tick) begin
                    if (pre_term) begin
                        prescale_count_value <= 16'h0000;
                    end else begin
                        prescale_count_value <= prescale_count_value + 16'h0001;
                    end
                end
            end
        end
    end

    // configuration registers, written by software
    integer k; // loop index of the configuration process
    integer m; // loop index of the match pin process
    integer p; // loop index of the output process
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            prescale_limit_value    <= 16'h0000;
            match_control_reg       <= 12'h000;
            capture_control_reg     <= 3'h0;
            count_mode_reg          <= 4'h0;
            pulse_width_control_reg <= 2'h0;
            for (k = 0; k < 4; k = k + 1) begin
                match_value_reg[k] <= 16'h0000;
            end
        end else if (wr_en) begin
            case (REG_ADDR)
                `OFS_PRESCALE_LIMIT: prescale_limit_value    <= REG_WDATA[15:0];
                `OFS_MATCH_CONTROL:  match_control_reg       <= REG_WDATA[11:0];
                `OFS_MATCH_VALUE_0:  match_value_reg[0]      <= REG_WDATA[15:0];
                `OFS_MATCH_VALUE_1:  match_value_reg[1]      <= REG_WDATA[15:0];
                `OFS_MATCH_VALUE_2:  match_value_reg[2]      <= REG_WDATA[15:0];
                `OFS_MATCH_VALUE_3:  match_value_reg[3]      <= REG_WDATA[15:0];
                `OFS_CAPTURE_CTRL:   capture_control_reg     <= REG_WDATA[2:0];
                `OFS_COUNT_MODE:     count_mode_reg          <= REG_WDATA[3:0];
                `OFS_PULSE_WIDTH:    pulse_width_control_reg <= REG_WDATA[1:0];
                default:             count_mode_reg          <= count_mode_reg;
            endcase
        end
    end

    // capture register loads the timer value on a selected edge, in timer mode only
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            capture_value_zero <= 16'h0000;
        end else if (cap_event && count_mode_reg[1:0] == 2'h0) begin
            capture_value_zero <= timer_count_value;
        end
    end

    // interrupt flags: set wins over write-one clear
    wire [`FLAG_WIDTH-1:0] flag_set =
        {cap_event & capture_control_reg[`CCR_IRQ], match_irq};
    wire [`FLAG_WIDTH-1:0] flag_clr =
        (wr_en && REG_ADDR == `OFS_IRQ_FLAGS) ? REG_WDATA[4:0] : 5'h00;
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_flag_reg <= 5'h00;
        end else begin
            irq_flag_reg <= (irq_flag_reg & ~flag_clr) | flag_set;
        end
    end

    // match pin state bits and actions; match toggles/sets/clears
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            external_match_reg <= 8'h00;
            match_hit_reg      <= 2'h0;
        end else begin
            match_hit_reg <= match_eq[1:0];
            if (wr_en && REG_ADDR == `OFS_EXT_MATCH) begin
                external_match_reg <= REG_WDATA[7:0];
            end else begin
                // act once per match entry, for channels 0 and 1
                for (m = 0; m < 2; m = m + 1) begin
                    if (match_eq[m] && !match_hit_reg[m]) begin
                        case (external_match_reg[`EMR_MATCH_ACTIONS+2*m +: 2])
                            2'h1:    external_match_reg[m] <= 1'b0;
                            2'h2:    external_match_reg[m] <= 1'b1;
                            2'h3:    external_match_reg[m] <= ~external_match_reg[m];
                            default: external_match_reg[m] <= external_match_reg[m];
                        endcase
                    end
                end
            end
        end
    end

    // outputs: pins, pwm, interrupt request, read data
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            MATCH_OUTPUT_PINS <= 2'h0;
            IRQ               <= 1'b0;
            REG_RDATA         <= `RESET_ZERO;
        end else begin
            // pwm: low until match, high after match, period by clear
            for (p = 0; p < 2; p = p + 1) begin
                if (pulse_width_control_reg[p]) begin
                    MATCH_OUTPUT_PINS[p] <= (timer_count_value >= match_value_reg[p]);
                end else begin
                    MATCH_OUTPUT_PINS[p] <= external_match_reg[p];
                end
            end
            IRQ <= |irq_flag_reg;
            // register read, reserved bits read zero
            if (REG_SEL && !REG_WRITE) begin
                case (REG_ADDR)
                    `OFS_IRQ_FLAGS:      REG_RDATA <= {27'h0, irq_flag_reg};
                    `OFS_TIMER_CONTROL:  REG_RDATA <= {30'h0, timer_control_reg};
                    `OFS_TIMER_COUNT:    REG_RDATA <= {16'h0, timer_count_value};
                    `OFS_PRESCALE_LIMIT: REG_RDATA <= {16'h0, prescale_limit_value};
                    `OFS_PRESCALE_COUNT: REG_RDATA <= {16'h0, prescale_count_value};
                    `OFS_MATCH_CONTROL:  REG_RDATA <= {20'h0, match_control_reg};
                    `OFS_MATCH_VALUE_0:  REG_RDATA <= {16'h0, match_value_reg[0]};
                    `OFS_MATCH_VALUE_1:  REG_RDATA <= {16'h0, match_value_reg[1]};
                    `OFS_MATCH_VALUE_2:  REG_RDATA <= {16'h0, match_value_reg[2]};
                    `OFS_MATCH_VALUE_3:  REG_RDATA <= {16'h0, match_value_reg[3]};
                    `OFS_CAPTURE_CTRL:   REG_RDATA <= {29'h0, capture_control_reg};
                    `OFS_CAPTURE_VALUE:  REG_RDATA <= {16'h0, capture_value_zero};
                    `OFS_EXT_MATCH:      REG_RDATA <= {24'h0, external_match_reg};
                    `OFS_COUNT_MODE:     REG_RDATA <= {28'h0, count_mode_reg};
                    `OFS_PULSE_WIDTH:    REG_RDATA <= {30'h0, pulse_width_control_reg};
                    default:             REG_RDATA <= `RESET_ZERO;
                endcase
            end
        end
    end
endmodule // tmr16_timer

//--- tmr16_timer_props.sv
/* checker for the timer register port and pins.
   assumes one clock and the active-low reset of the timer. */
`timescale 1ns/100ps
module tmr16_timer_props (
    // clock and reset
    input wire        CLOCK,
    input wire        ARST_N,
    // register port
    input wire        REG_SEL,
    input wire        REG_WRITE,
    input wire [7:0]  REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire [31:0] REG_RDATA,
    // pins
    input wire        CAPTURE_INPUT_PIN,
    input wire [1:0]  MATCH_OUTPUT_PINS,
    input wire        IRQ
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    // decoded accesses
    wire rd = REG_SEL && !REG_WRITE;
    wire wr = REG_SEL && REG_WRITE;
    irq_flag_link_a: assert property (rd && REG_ADDR == 8'h00 |=> IRQ == (|REG_RDATA[4:0]))
        else $error("irq disagrees with flags");
    flag_reserved_a: assert property (rd && REG_ADDR == 8'h00 |=> REG_RDATA[31:5] == 27'h0)
        else $error("flag upper bits set");
    rdata_hold_a: assert property (!rd |=> $stable(REG_RDATA))
        else $error("read data moved");
    limit_readback_a: assert property (wr && REG_ADDR == 8'h0C ##1 rd && REG_ADDR == 8'h0C
        |=> REG_RDATA == {16'h0000, $past(REG_WDATA[15:0], 2)}) else $error("limit readback");
    clear_zeroes_a: assert property (wr && REG_ADDR == 8'h04 && REG_WDATA[1] ##1 !wr
        ##1 rd && REG_ADDR == 8'h08 |=> REG_RDATA == 32'h0) else $error("count not cleared");
    count_width_a: assert property (rd && REG_ADDR inside {8'h08, 8'h10} |=> REG_RDATA[31:16] == 16'h0)
        else $error("count wider than 16 bits");
    reset_quiet_a: assert property ($rose(ARST_N) |-> !IRQ && MATCH_OUTPUT_PINS == 2'b00)
        else $error("outputs not idle after reset");
    unmapped_read_a: assert property (rd && REG_ADDR == 8'h40 |=> REG_RDATA == 32'h0)
        else $error("unmapped read not zero");
    // main scenarios seen
    cover property ($rose(IRQ));
    cover property ($rose(CAPTURE_INPUT_PIN));
    cover property (MATCH_OUTPUT_PINS == 2'b01);
endmodule // tmr16_timer_props
bind tmr16_timer tmr16_timer_props tmr16_timer_props_inst (.CLOCK(CLOCK), .ARST_N(ARST_N), .REG_SEL(REG_SEL),
    .REG_WRITE(REG_WRITE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .CAPTURE_INPUT_PIN(CAPTURE_INPUT_PIN), .MATCH_OUTPUT_PINS(MATCH_OUTPUT_PINS), .IRQ(IRQ));
